// file: srdp_pkg.sv
// shared constants and types for the stream receive dma path
`default_nettype none
package srdp_pkg;
  // receive store size in bytes, stored as 32-bit words
  localparam int FIFO_BYTES = 8388608;
  localparam int FIFO_AW_DEF = $clog2(FIFO_BYTES / 4);

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DESC = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0c;

  // control fields
  localparam int CTRL_RCV_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_GO_BIT = 2;
  localparam logic CTRL_RCV_RST = 1'b0;
  localparam logic CTRL_RCV_IDLE = 1'b0;
  localparam logic CTRL_RCV_ACCEPT = 1'b1;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_OVF_BIT = 2;
  localparam int STAT_EMPTY_BIT = 3;

  // descriptor layout: word 0 buffer address, 1 byte count, 2 next/flags
  localparam logic [1:0] DESC_W_ADDR = 2'h0;
  localparam logic [1:0] DESC_W_COUNT = 2'h1;
  localparam logic [1:0] DESC_W_NEXT = 2'h2;
  localparam int DESC_LAST_BIT = 0;
  localparam int DESC_IRQ_BIT = 1;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_FETCH,
    DMA_XFER
  } srdp_dma_t;
endpackage : srdp_pkg
`default_nettype wire

// file: srdp_mem.sv
// word memory behind the receive store, registered read port
`default_nettype none
module srdp_mem #(
  parameter int DW = 32,
  parameter int AW = 21
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] store [2**AW];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (re)
    begin
      rdata <= store[raddr];
    end
  end
endmodule : srdp_mem
`default_nettype wire

// file: srdp_packer.sv
// gathers stream bytes into little-endian words in arrival order
`default_nettype none
module srdp_packer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_byte,
  output logic             out_valid,
  output logic      [31:0] out_word
);
  logic [1:0]  cnt;
  logic [23:0] acc;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt       <= 2'h0;
      acc       <= 24'h00_0000;
      out_valid <= 1'b0;
      out_word  <= 32'h0000_0000;
    end
    else if (clr)
    begin
      cnt       <= 2'h0;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= en && in_valid && (cnt == 2'h3);
      if (en && in_valid)
      begin
        cnt <= cnt + 2'h1;
        // first byte to lowest lane
        acc <= {in_byte, acc[23:8]};
        if (cnt == 2'h3)
        begin
          out_word <= {in_byte, acc};
        end
      end
    end
  end
endmodule : srdp_packer
`default_nettype wire

// file: srdp_rx_dma.sv
// receive store, demand-paced scatter/gather dma and register slave
`default_nettype none
module srdp_rx_dma
#(
  parameter int FIFO_AW = srdp_pkg::FIFO_AW_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        st_valid,
  input  wire logic [7:0]  st_data,
  output logic             hm_req,
  output logic             hm_write,
  output logic      [31:0] hm_addr,
  output logic      [31:0] hm_wdata,
  input  wire logic        hm_ack,
  input  wire logic [31:0] hm_rdata,
  output logic             dma_done_irq
);
  import srdp_pkg::*;
  logic              wr_pend;
  logic [7:0]        wr_off;
  logic              rcv;
  logic [31:0]       desc_base;
  logic              done;
  logic              irq_en;
  logic              ovf;
  logic              soft_rst;
  logic              go;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              ahb_take;
  logic [31:0]       rd_val;
  logic              pk_valid;
  logic [31:0]       pk_word;
  logic [FIFO_AW:0]  wr_ptr;
  logic [FIFO_AW:0]  rd_ptr;
  logic [FIFO_AW:0]  level;
  logic              fifo_empty;
  logic              fifo_full;
  logic              push;
  logic              rd_en;
  logic              head_v;
  logic [31:0]       head_word;
  srdp_dma_t         state;
  logic [31:0]       fetch_addr;
  logic [1:0]        widx;
  logic [31:0]       cur_addr;
  logic [31:0]       left;
  logic [31:0]       nxt;
  logic              wr_ack;
  logic              xfer_end;
  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_off  <= 8'h00;
    end
    else
    begin
      wr_pend <= ahb_take && hwrite;
      if (ahb_take)
      begin
        wr_off <= haddr[7:0];
      end
    end
  end
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_CTRL:  rd_val[CTRL_RCV_BIT] = rcv;
      OFF_DESC:  rd_val = desc_base;
      OFF_STAT:
      begin
        rd_val[STAT_BUSY_BIT]  = state != DMA_IDLE;
        rd_val[STAT_DONE_BIT]  = done;
        rd_val[STAT_OVF_BIT]   = ovf;
        rd_val[STAT_EMPTY_BIT] = fifo_empty && !head_v;
      end
      OFF_LEVEL: rd_val[FIFO_AW:0] = level;
      default:   rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (ahb_take && !hwrite)
    begin
      hrdata <= rd_val;
    end
  end
  assign wr_ctrl  = wr_pend && (wr_off == OFF_CTRL);
  assign wr_stat  = wr_pend && (wr_off == OFF_STAT);
  assign soft_rst = wr_ctrl && hwdata[CTRL_RST_BIT];
  assign go       = wr_ctrl && hwdata[CTRL_GO_BIT] && !soft_rst;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rcv <= CTRL_RCV_RST;
    end
    else if (soft_rst)
    begin
      rcv <= CTRL_RCV_IDLE;
    end
    else if (wr_ctrl)
    begin
      rcv <= hwdata[CTRL_RCV_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      desc_base <= DESC_BASE_RST;
    end
    else if (wr_pend && (wr_off == OFF_DESC))
    begin
      desc_base <= {hwdata[31:2], 2'b00};
    end
  end
  srdp_packer u_packer (
    .clk       (hclk),
    .rstn      (hresetn),
    .clr       (soft_rst),
    .en        (rcv == CTRL_RCV_ACCEPT),
    .in_valid  (st_valid),
    .in_byte   (st_data),
    .out_valid (pk_valid),
    .out_word  (pk_word)
  );
  assign level      = wr_ptr - rd_ptr;
  assign fifo_empty = wr_ptr == rd_ptr;
  assign fifo_full  = level[FIFO_AW];
  assign push       = pk_valid && !fifo_full;
  assign rd_en      = !head_v && !fifo_empty && !soft_rst;
  srdp_mem #(
    .DW (32),
    .AW (FIFO_AW)
  ) u_mem (
    .clk   (hclk),
    .we    (push),
    .waddr (wr_ptr[FIFO_AW-1:0]),
    .wdata (pk_word),
    .re    (rd_en),
    .raddr (rd_ptr[FIFO_AW-1:0]),
    .rdata (head_word)
  );
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      head_v <= 1'b0;
    end
    else if (soft_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      head_v <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (rd_en)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        head_v <= 1'b1;
      end
      else if (wr_ack)
      begin
        head_v <= 1'b0;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf <= 1'b0;
    end
    else if (pk_valid && fifo_full)
    begin
      ovf <= 1'b1;
    end
    else if (wr_stat && hwdata[STAT_OVF_BIT])
    begin
      ovf <= 1'b0;
    end
  end
  assign hm_write = state == DMA_XFER;
  assign hm_req   = (state == DMA_FETCH) || (hm_write && head_v && (left != 32'h0000_0000));
  assign hm_addr  = hm_write ? cur_addr : fetch_addr;
  assign hm_wdata = head_word;
  assign wr_ack   = hm_ack && hm_req && hm_write;
  assign xfer_end = hm_write && ((wr_ack && left <= WORD_BYTES) || left == 32'h0000_0000);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= DMA_IDLE;
      fetch_addr <= 32'h0000_0000;
      widx       <= DESC_W_ADDR;
      cur_addr   <= 32'h0000_0000;
      left       <= 32'h0000_0000;
      nxt        <= 32'h0000_0000;
    end
    else if (soft_rst)
    begin
      state <= DMA_IDLE;
    end
    else
    begin
      unique case (state)
        DMA_IDLE:
        begin
          if (go)
          begin
            fetch_addr <= desc_base;
            widx       <= DESC_W_ADDR;
            state      <= DMA_FETCH;
          end
        end
        DMA_FETCH:
        begin
          if (hm_ack)
          begin
            fetch_addr <= fetch_addr + WORD_BYTES;
            widx       <= widx + 2'h1;
            unique case (widx)
              DESC_W_ADDR:  cur_addr <= {hm_rdata[31:2], 2'b00};
              DESC_W_COUNT: left <= hm_rdata;
              default:
              begin
                nxt   <= hm_rdata;
                state <= DMA_XFER;
              end
            endcase
          end
        end
        DMA_XFER:
        begin
          if (wr_ack)
          begin
            cur_addr <= cur_addr + WORD_BYTES;
            left     <= left - WORD_BYTES;
          end
          if (xfer_end)
          begin
            widx       <= DESC_W_ADDR;
            fetch_addr <= {nxt[31:2], 2'b00};
            state      <= nxt[DESC_LAST_BIT] ? DMA_IDLE : DMA_FETCH;
          end
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done   <= 1'b0;
      irq_en <= 1'b0;
    end
    else if (xfer_end && nxt[DESC_LAST_BIT] && !soft_rst)
    begin
      done   <= 1'b1;
      irq_en <= nxt[DESC_IRQ_BIT];
    end
    else if (wr_stat && hwdata[STAT_DONE_BIT])
    begin
      done <= 1'b0;
    end
  end

  assign dma_done_irq = done && irq_en;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_last_word;
    xfer_end && nxt[DESC_LAST_BIT] && !soft_rst;
  endsequence
  sequence s_flag_up;
    done ##0 (dma_done_irq == irq_en);
  endsequence
  AST_NO_UNDERFLOW: assert property (hm_req && hm_write |-> head_v)
    else $error("write requested with no store data");
  AST_STALL_EMPTY: assert property ((state == DMA_XFER) && !head_v && fifo_empty |-> !hm_req)
    else $error("request while store empty");
  AST_IDLE_NO_ADMIT: assert property (!rcv && !$past(rcv) |-> !push)
    else $error("data admitted while idle");
  AST_RESET_CLEARS: assert property (soft_rst |=> fifo_empty && !head_v && !rcv && state == DMA_IDLE)
    else $error("adapter reset left state behind");
  AST_OVERFLOW: assert property (pk_valid && fifo_full && !soft_rst |=> ovf && $stable(wr_ptr))
    else $error("overflow not flagged");
  AST_DONE_AFTER_LAST: assert property ($rose(done) |-> $past(xfer_end))
    else $error("done raised without final word");
  AST_ORDER: assert property (wr_ack && !soft_rst |=> cur_addr == $past(cur_addr) + WORD_BYTES)
    else $error("buffer address not ascending");
  AST_CHAIN_IRQ: assert property (s_last_word ##0 nxt[DESC_IRQ_BIT] |=> s_flag_up ##0 dma_done_irq)
    else $error("chain end interrupt missing");
  AST_ADMIT: assert property (rcv && pk_valid && !fifo_full && !soft_rst |=> level == $past(level) + 1'b1 || $past(rd_en))
    else $error("accepted word not stored");
endmodule : srdp_rx_dma
`default_nettype wire

// file: srdp_host_mem.sv
// host memory model answering dma requests after a variable delay
`default_nettype none
module srdp_host_mem (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [1:0]  lat,
  output logic             ack,
  output logic      [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack      <= 1'b0;
      wait_cnt <= 2'h0;
      rdata    <= 32'h0000_0000;
    end
    else if (ack)
    begin
      ack   <= 1'b0;
      rdata <= ~rdata;
    end
    else if (req && wait_cnt >= lat)
    begin
      ack      <= 1'b1;
      wait_cnt <= 2'h0;
      if (wr)
        mem[addr[9:2]] <= wdata;
      else
        rdata <= mem[addr[9:2]];
    end
    else if (req)
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule : srdp_host_mem
`default_nettype wire

// file: srdp_tb_top.sv
// self-checking bench for the stream receive dma path
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h, expected %h", $time, a, e); end end
module srdp_tb_top;
  import srdp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, st_valid = 1'b0;
  logic        hready, hreadyout, hresp, hm_req, hm_write, hm_ack, dma_done_irq;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [31:0] hrdata, hm_addr, hm_wdata, hm_rdata, rd;
  logic [1:0]  htrans = 2'b00, lat = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [7:0]  st_data = 8'h00;
  logic [7:0]  sent[$];
  int          fails = 0, compares = 0, seed = 69215, c0, c1;
  assign hready = hreadyout;

  srdp_rx_dma #(.FIFO_AW(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .st_valid(st_valid), .st_data(st_data),
    .hm_req(hm_req), .hm_write(hm_write), .hm_addr(hm_addr), .hm_wdata(hm_wdata), .hm_ack(hm_ack),
    .hm_rdata(hm_rdata), .dma_done_irq(dma_done_irq));
  srdp_host_mem u_host (.clk(hclk), .rstn(hresetn), .req(hm_req), .wr(hm_write), .addr(hm_addr),
    .wdata(hm_wdata), .lat(lat), .ack(hm_ack), .rdata(hm_rdata));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // slow and prompt host answers
  always @(posedge hclk) lat <= 2'($random(seed));

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic feed(input int n, input bit gap, input bit keep);
    logic [7:0] b;
    for (int k = 0; k < n; k++)
    begin
      b = 8'($random(seed));
      st_valid <= 1'b1;
      st_data  <= b;
      if (keep) sent.push_back(b);
      @(posedge hclk);
      if (gap)
      begin
        st_valid <= 1'b0;
        @(posedge hclk);
      end
    end
    if (!gap) st_valid <= 1'b0;
  endtask : feed

  function automatic logic [31:0] phys(input int k);
    return (k < c0) ? 32'h0000_0100 + 32'(k) : 32'h0000_0200 + 32'(k - c0);
  endfunction : phys

  task automatic chain(input logic irq_en);
    int t;
    c0 = 4 * ({$random(seed)} % 5);
    c1 = 4 * (1 + {$random(seed)} % 4);
    sent.delete();
    u_host.mem[0] = 32'h0000_0100;
    u_host.mem[1] = 32'(c0);
    u_host.mem[2] = 32'h0000_0010;
    u_host.mem[4] = 32'h0000_0200;
    u_host.mem[5] = 32'(c1);
    u_host.mem[6] = {30'h0000_0000, irq_en, 1'b1};
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    bus(1'b1, OFF_DESC, 32'h0000_0000);
    bus(1'b1, OFF_CTRL, 32'h0000_0004);
    feed(4, 1'b0, 1'b0);
    repeat (40) @(posedge hclk);
    `CHK(hm_req, 1'b0)
    bus(1'b0, OFF_LEVEL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    feed(c0 + c1, 1'({$random(seed)} % 2), 1'b1);
    t = 0;
    do
    begin
      bus(1'b0, OFF_STAT, 32'h0000_0000);
      t++;
    end
    while (rd[STAT_DONE_BIT] !== 1'b1 && t < 400);
    `CHK(rd[STAT_DONE_BIT], 1'b1)
    `CHK(dma_done_irq, irq_en)
    for (int k = 0; k < c0 + c1; k++)
      `CHK(u_host.mem[phys(k) >> 2][8 * (k % 4) +: 8], sent[k])
    bus(1'b1, OFF_STAT, 32'h0000_0002);
    @(posedge hclk);
    `CHK(dma_done_irq, 1'b0)
  endtask : chain

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK({hreadyout, hresp, dma_done_irq}, 3'b100)
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008)
    bus(1'b1, OFF_DESC, 32'h0000_0013);
    bus(1'b0, OFF_DESC, 32'h0000_0000);
    `CHK(rd, 32'h0000_0010)
    bus(1'b0, 8'h40, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      chain(1'(i != 1));
      $display("test chain %0d done", i);
    end
    bus(1'b1, OFF_CTRL, 32'h0000_0001);
    feed(60, 1'b0, 1'b0);
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    `CHK(rd[STAT_OVF_BIT], 1'b0)
    feed(20, 1'b0, 1'b0);
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    `CHK(rd[STAT_OVF_BIT], 1'b1)
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    `CHK(rd[STAT_EMPTY_BIT], 1'b1)
    feed(8, 1'b0, 1'b0);
    bus(1'b0, OFF_LEVEL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, OFF_STAT, 32'h0000_0004);
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    `CHK(rd[STAT_OVF_BIT], 1'b0)
    $display("test overflow done");
    conclude();
  end
endmodule : srdp_tb_top
`default_nettype wire
